// ==== rtl/mspc_pkg.sv ====
// mspc_pkg: constants and types of the protocol configuration register bank
// assumes a 250 MHz system clock and a control-transaction engine in front
package mspc_pkg;

    localparam int CLK_MHZ = 250;

    // register addresses inside memory map zero
    localparam logic [7:0] ADDR_CAP = 8'h02;
    localparam logic [7:0] ADDR_RST = 8'h03;
    localparam logic [7:0] ADDR_CFG = 8'h04;

    // capability word fields
    localparam int CAP_FCS_CHECK_BIT = 10;
    localparam int CAP_DIRECT_PHY_BIT = 8;
    localparam int CAP_CUT_THROUGH_BIT = 7;
    localparam int CAP_TIMESTAMP_BIT = 6;
    localparam int CAP_INCR_DISABLE_BIT = 5;
    localparam int CAP_SEQUENCING_BIT = 4;
    localparam logic [2:0] CAP_MIN_CHUNK_VAL = 3'h3;
    localparam logic [31:0] CAP_VALUE = (32'h1 << CAP_FCS_CHECK_BIT)
        | (32'h1 << CAP_DIRECT_PHY_BIT) | (32'h1 << CAP_CUT_THROUGH_BIT)
        | (32'h1 << CAP_INCR_DISABLE_BIT) | {29'h0, CAP_MIN_CHUNK_VAL};

    // soft reset word
    localparam int RST_BIT = 0;

    // configuration word fields
    localparam int CFG_SYNC_BIT = 15;
    localparam int CFG_FCS_CHECK_BIT = 14;
    localparam int CFG_CS_ALIGN_BIT = 13;
    localparam int CFG_ZERO_ALIGN_BIT = 12;
    localparam int CFG_THR_LSB = 10;
    localparam int CFG_TX_CUT_BIT = 9;
    localparam int CFG_RX_CUT_BIT = 8;
    localparam int CFG_PROTECT_BIT = 5;
    localparam int CFG_PAYLOAD_LSB = 0;
    localparam logic [2:0] PAYLOAD_MIN = 3'h3;
    localparam logic [2:0] PAYLOAD_MAX = 3'h6;
    localparam logic [2:0] PAYLOAD_RESET = 3'h6;
    localparam logic [1:0] THR_RESET = 2'h0;

    // transmit credit thresholds per code
    localparam logic [5:0] THR_CODE0 = 6'h01;
    localparam logic [5:0] THR_CODE1 = 6'h04;
    localparam logic [5:0] THR_CODE2 = 6'h08;
    localparam logic [5:0] THR_CODE3 = 6'h10;

    // length of the mac and phy reset pulse
    localparam int SOFT_RST_NS = 1000;
    localparam int SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } mspc_req_type;

    typedef struct packed {
        logic config_done;
        logic tx_checksum_validate_en;
        logic chipselect_align_rx_en;
        logic zero_offset_align_rx_en;
        logic [1:0] tx_credit_irq_threshold;
        logic tx_cut_through_en;
        logic rx_cut_through_en;
        logic control_protection_en;
        logic [2:0] chunk_payload_size;
    } mspc_cfg_type;

    typedef enum logic [1:0] {
        SR_IDLE = 2'h0,
        SR_WAIT_CS = 2'h1,
        SR_RUN = 2'h3,
        SR_DONE = 2'h2
    } mspc_sr_type;

endpackage

// ==== rtl/mspc_sync.sv ====
// mspc_sync: two flip-flop level synchroniser
// assumes the input is a level that stays put for several destination clocks
`timescale 1ns/1ns
`default_nettype none
module mspc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r, meta_nxt;
    logic [W-1:0] q_r, q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // mspc_sync
`default_nettype wire

// ==== rtl/mspc_regs.sv ====
// mspc_regs: capability, soft reset and protocol configuration registers
// assumes a control-transaction engine on clk_sys presents register requests,
// and chunk framing logic on the link clock asks where a receive frame may start
`timescale 1ns/1ns
`default_nettype none
module mspc_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_link,
    input wire logic link_rstn,
    input wire mspc_pkg::mspc_req_type reg_req,
    output logic [31:0] reg_rdata,
    output logic reg_rsp_valid,
    input wire logic chip_select_n,
    input wire logic [5:0] tx_credits,
    input wire logic ctrl_protect_err,
    input wire logic reset_complete_clr,
    input wire logic protection_error_clr,
    output mspc_pkg::mspc_cfg_type cfg,
    output logic frames_accept,
    output logic mac_phy_reset,
    output logic reset_complete_flag,
    output logic protection_error_flag,
    output logic tx_credit_irq,
    input wire logic link_chunk_start,
    input wire logic link_chunk_first,
    output logic link_rx_start_ok,
    output logic link_tx_fcs_check
);
    import mspc_pkg::*;

    mspc_cfg_type cfg_r, cfg_nxt;
    logic rst_req_r, rst_req_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rsp_r, rsp_nxt;
    logic [7:0] rd_addr_r, rd_addr_nxt;
    logic [31:0] cfg_word;
    logic cs_high;
    mspc_sr_type sr_state_r, sr_nxt;
    logic [15:0] sr_cnt_r, sr_cnt_nxt;
    logic mac_rst_r, mac_rst_nxt;
    logic rc_flag_r, rc_flag_nxt;
    logic pe_flag_r, pe_flag_nxt;
    logic armed_r, armed_nxt;
    logic irq_r, irq_nxt;
    logic accept_r, accept_nxt;
    logic [5:0] thr_val;
    logic credit_ok;
    logic [2:0] link_cfg;

    // chip select pin into the system domain
    mspc_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk(clk_sys),
        .rstn(rstn),
        .d(chip_select_n),
        .q(cs_high)
    );

    // readback image of the configuration word
    always_comb begin
        cfg_word = '0;
        cfg_word[CFG_SYNC_BIT] = cfg_r.config_done;
        cfg_word[CFG_FCS_CHECK_BIT] = cfg_r.tx_checksum_validate_en;
        cfg_word[CFG_CS_ALIGN_BIT] = cfg_r.chipselect_align_rx_en;
        cfg_word[CFG_ZERO_ALIGN_BIT] = cfg_r.zero_offset_align_rx_en;
        cfg_word[CFG_THR_LSB +: 2] = cfg_r.tx_credit_irq_threshold;
        cfg_word[CFG_TX_CUT_BIT] = cfg_r.tx_cut_through_en;
        cfg_word[CFG_RX_CUT_BIT] = cfg_r.rx_cut_through_en;
        cfg_word[CFG_PROTECT_BIT] = cfg_r.control_protection_en;
        cfg_word[CFG_PAYLOAD_LSB +: 3] = cfg_r.chunk_payload_size;
    end

    // register access
    always_comb begin
        cfg_nxt = cfg_r;
        rst_req_nxt = rst_req_r;
        rdata_nxt = rdata_r;
        rd_addr_nxt = rd_addr_r;
        rsp_nxt = reg_req.valid & ~reg_req.write;
        if (sr_state_r == SR_WAIT_CS && cs_high) begin
            rst_req_nxt = 1'b0;
        end
        if (reg_req.valid && reg_req.write) begin
            case (reg_req.addr)
                ADDR_RST: begin
                    if (reg_req.wdata[RST_BIT]) begin
                        rst_req_nxt = 1'b1;
                    end
                end
                ADDR_CFG: begin
                    // a written zero never clears configuration-done
                    cfg_nxt.config_done = cfg_r.config_done
                        | reg_req.wdata[CFG_SYNC_BIT];
                    cfg_nxt.tx_checksum_validate_en = reg_req.wdata[CFG_FCS_CHECK_BIT];
                    cfg_nxt.chipselect_align_rx_en = reg_req.wdata[CFG_CS_ALIGN_BIT];
                    cfg_nxt.zero_offset_align_rx_en = reg_req.wdata[CFG_ZERO_ALIGN_BIT];
                    cfg_nxt.tx_credit_irq_threshold = reg_req.wdata[CFG_THR_LSB +: 2];
                    cfg_nxt.tx_cut_through_en = reg_req.wdata[CFG_TX_CUT_BIT];
                    cfg_nxt.rx_cut_through_en = reg_req.wdata[CFG_RX_CUT_BIT];
                    cfg_nxt.control_protection_en = reg_req.wdata[CFG_PROTECT_BIT];
                    // unsupported payload size codes leave the field unchanged
                    if (reg_req.wdata[CFG_PAYLOAD_LSB +: 3] >= PAYLOAD_MIN
                        && reg_req.wdata[CFG_PAYLOAD_LSB +: 3] <= PAYLOAD_MAX) begin
                        cfg_nxt.chunk_payload_size = reg_req.wdata[CFG_PAYLOAD_LSB +: 3];
                    end
                end
                default: begin
                    // capability word and unmapped addresses take no writes
                end
            endcase
        end
        if (reg_req.valid && !reg_req.write) begin
            rd_addr_nxt = reg_req.addr;
            case (reg_req.addr)
                ADDR_CAP: rdata_nxt = CAP_VALUE;
                ADDR_RST: rdata_nxt = {31'h0, rst_req_r};
                ADDR_CFG: rdata_nxt = cfg_word;
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cfg_r <= '{config_done: 1'b0, tx_checksum_validate_en: 1'b0,
                chipselect_align_rx_en: 1'b0, zero_offset_align_rx_en: 1'b0,
                tx_credit_irq_threshold: THR_RESET, tx_cut_through_en: 1'b0,
                rx_cut_through_en: 1'b0, control_protection_en: 1'b0,
                chunk_payload_size: PAYLOAD_RESET};
            rst_req_r <= 1'b0;
            rdata_r <= 32'h0;
            rsp_r <= 1'b0;
            rd_addr_r <= 8'h0;
        end else begin
            cfg_r <= cfg_nxt;
            rst_req_r <= rst_req_nxt;
            rdata_r <= rdata_nxt;
            rsp_r <= rsp_nxt;
            rd_addr_r <= rd_addr_nxt;
        end
    end

    // soft reset sequence: wait for chip select release, pulse, report completion
    always_comb begin
        sr_nxt = sr_state_r;
        sr_cnt_nxt = sr_cnt_r;
        case (sr_state_r)
            SR_IDLE: begin
                if (rst_req_r) begin
                    sr_nxt = SR_WAIT_CS;
                end
            end
            SR_WAIT_CS: begin
                if (cs_high) begin
                    sr_nxt = SR_RUN;
                    sr_cnt_nxt = 16'(SOFT_RST_CYC - 1);
                end
            end
            SR_RUN: begin
                if (sr_cnt_r == 16'h0) begin
                    sr_nxt = SR_DONE;
                end else begin
                    sr_cnt_nxt = sr_cnt_r - 16'h1;
                end
            end
            SR_DONE: sr_nxt = SR_IDLE;
            default: sr_nxt = SR_IDLE;
        endcase
        mac_rst_nxt = (sr_nxt == SR_RUN);
        // set wins over a clear in the same cycle
        rc_flag_nxt = (sr_state_r == SR_DONE) | (rc_flag_r & ~reset_complete_clr);
        pe_flag_nxt = (ctrl_protect_err & cfg_r.control_protection_en)
            | (pe_flag_r & ~protection_error_clr);
        accept_nxt = cfg_nxt.config_done;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sr_state_r <= SR_IDLE;
            sr_cnt_r <= 16'h0;
            mac_rst_r <= 1'b0;
            rc_flag_r <= 1'b1;
            pe_flag_r <= 1'b0;
            accept_r <= 1'b0;
        end else begin
            sr_state_r <= sr_nxt;
            sr_cnt_r <= sr_cnt_nxt;
            mac_rst_r <= mac_rst_nxt;
            rc_flag_r <= rc_flag_nxt;
            pe_flag_r <= pe_flag_nxt;
            accept_r <= accept_nxt;
        end
    end

    // transmit credit interrupt re-arm
    always_comb begin
        case (cfg_r.tx_credit_irq_threshold)
            2'h0: thr_val = THR_CODE0;
            2'h1: thr_val = THR_CODE1;
            2'h2: thr_val = THR_CODE2;
            default: thr_val = THR_CODE3;
        endcase
        credit_ok = (tx_credits >= thr_val);
        irq_nxt = armed_r & credit_ok;
        armed_nxt = (tx_credits == 6'h0) | (armed_r & ~credit_ok);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            armed_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
            irq_r <= irq_nxt;
        end
    end

    // alignment and check enables into the link domain
    mspc_sync #(.W(3), .RST_VAL(3'h0)) u_link_sync (
        .clk(clk_link),
        .rstn(link_rstn),
        .d({cfg_r.tx_checksum_validate_en, cfg_r.chipselect_align_rx_en,
            cfg_r.zero_offset_align_rx_en}),
        .q(link_cfg)
    );

    // where a receive frame may begin
    always_comb begin
        if (link_cfg[1]) begin
            link_rx_start_ok = link_chunk_start & link_chunk_first;
        end else if (link_cfg[0]) begin
            link_rx_start_ok = link_chunk_start;
        end else begin
            link_rx_start_ok = 1'b1;
        end
    end

    assign link_tx_fcs_check = link_cfg[2];
    assign reg_rdata = rdata_r;
    assign reg_rsp_valid = rsp_r;
    assign cfg = cfg_r;
    assign frames_accept = accept_r;
    assign mac_phy_reset = mac_rst_r;
    assign reset_complete_flag = rc_flag_r;
    assign protection_error_flag = pe_flag_r;
    assign tx_credit_irq = irq_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_cap_cut_one: assert property (reg_rsp_valid && rd_addr_r == ADDR_CAP
        |-> reg_rdata[CAP_CUT_THROUGH_BIT]) else $error("cut-through capability not one");
    a_cap_stamp_zero: assert property (reg_rsp_valid && rd_addr_r == ADDR_CAP
        |-> !reg_rdata[CAP_TIMESTAMP_BIT]) else $error("timestamp capability not zero");
    a_cap_incr_one: assert property (reg_rsp_valid && rd_addr_r == ADDR_CAP
        |-> reg_rdata[CAP_INCR_DISABLE_BIT]) else $error("incr disable capability not one");
    a_cap_retry_zero: assert property (reg_rsp_valid && rd_addr_r == ADDR_CAP
        |-> !reg_rdata[CAP_SEQUENCING_BIT]) else $error("sequencing capability not zero");
    a_cap_min_chunk: assert property (reg_rsp_valid && rd_addr_r == ADDR_CAP
        |-> reg_rdata[2:0] == CAP_MIN_CHUNK_VAL) else $error("minimum chunk size wrong");
    a_reset_after_cs: assert property ($rose(mac_phy_reset) |-> $past(cs_high))
        else $error("mac and phy reset began with chip select active");
    a_reset_bit_clears: assert property ($rose(mac_phy_reset) |-> !rst_req_r)
        else $error("soft reset bit did not clear");
    a_accept_needs_done: assert property (!cfg.config_done |-> !frames_accept)
        else $error("frames accepted before configuration done");
    a_done_sticky: assert property (cfg.config_done |=> cfg.config_done)
        else $error("configuration done cleared without reset");
    a_credit_thresh: assert property (tx_credit_irq |-> $past(credit_ok) && $past(armed_r))
        else $error("credit interrupt below threshold");
    a_cfg_ro_zero: assert property (reg_rsp_valid && rd_addr_r == ADDR_CFG
        |-> reg_rdata[7:6] == 2'h0 && reg_rdata[31:16] == 16'h0)
        else $error("read-only configuration bits not zero");
    a_payload_legal: assert property (cfg.chunk_payload_size >= PAYLOAD_MIN
        && cfg.chunk_payload_size <= PAYLOAD_MAX) else $error("illegal payload size");
    a_reset_complete: assert property (sr_state_r == SR_DONE |=> reset_complete_flag)
        else $error("reset complete flag not set");
    a_prot_gated: assert property (!$past(cfg_r.control_protection_en)
        && !$past(pe_flag_r) |-> !protection_error_flag)
        else $error("protection error without protection");
    a_rst_unused_zero: assert property (reg_rsp_valid && rd_addr_r == ADDR_RST
        |-> reg_rdata[31:1] == 31'h0) else $error("unused reset bits not zero");
    a_cs_align: assert property (@(posedge clk_link) disable iff (!link_rstn)
        link_cfg[1] && !link_chunk_first |-> !link_rx_start_ok)
        else $error("frame start outside first chunk");
endmodule // mspc_regs
`default_nettype wire

// ==== test/mspc_host_model.sv ====
// mspc_host_model: host side of the link: chip select, link clock and chunk marks
// assumes the bench raises frame_on for the length of each frame
`timescale 1ns/1ns
`default_nettype none
module mspc_host_model (
    input wire logic frame_on,
    output logic clk_link,
    output logic chip_select_n,
    output logic link_chunk_start,
    output logic link_chunk_first
);
    logic [7:0] beat_r;
    assign chip_select_n = ~frame_on;
    // link clock runs only inside frames: 8 ns low, 7 ns high
    initial begin
        clk_link = 1'b0;
        forever begin
            #8;
            clk_link = ~chip_select_n;
            #7;
            clk_link = 1'b0;
        end
    end
    // four idle beats after chip select, then chunks of four beats
    always @(posedge clk_link or posedge chip_select_n) begin
        if (chip_select_n) begin
            beat_r <= 8'h00;
            link_chunk_start <= 1'b0;
            link_chunk_first <= 1'b0;
        end else begin
            beat_r <= beat_r + 8'h01;
            link_chunk_start <= (beat_r >= 8'h04) && (beat_r[1:0] == 2'h0);
            link_chunk_first <= (beat_r >= 8'h04) && (beat_r < 8'h08);
        end
    end
endmodule // mspc_host_model
`default_nettype wire

// ==== test/mspc_regs_tb.sv ====
// mspc_regs_tb: self-checking bench of the configuration register bank
// assumes the host model drives chip select, link clock and chunk marks
`timescale 1ns/1ns
`default_nettype none
module mspc_regs_tb;
    import mspc_pkg::*;
    logic clk_sys, rstn, link_rstn, frame_on, chk_link, clk_link, chip_select_n;
    logic ctrl_protect_err, reset_complete_clr, protection_error_clr;
    logic chunk_start, chunk_first, reg_rsp_valid, frames_accept, mac_phy_reset;
    logic reset_complete_flag, protection_error_flag, tx_credit_irq;
    logic link_rx_start_ok, link_tx_fcs_check;
    logic [5:0] tx_credits, thr;
    logic [31:0] reg_rdata, cfg_exp, seed, rd_val, w;
    mspc_req_type reg_req;
    mspc_cfg_type cfg;
    int n_errors, n_compared, cnt;
    localparam logic [31:0] CAP_EXP = 32'h00000400 | 32'h00000100 | 32'h000000A3;

    mspc_regs mspc_regs_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
        .link_rstn(link_rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rsp_valid(reg_rsp_valid), .chip_select_n(chip_select_n),
        .tx_credits(tx_credits), .ctrl_protect_err(ctrl_protect_err),
        .reset_complete_clr(reset_complete_clr), .protection_error_clr(protection_error_clr),
        .cfg(cfg), .frames_accept(frames_accept), .mac_phy_reset(mac_phy_reset),
        .reset_complete_flag(reset_complete_flag),
        .protection_error_flag(protection_error_flag), .tx_credit_irq(tx_credit_irq),
        .link_chunk_start(chunk_start), .link_chunk_first(chunk_first),
        .link_rx_start_ok(link_rx_start_ok), .link_tx_fcs_check(link_tx_fcs_check));
    mspc_host_model mspc_host_model_inst (.frame_on(frame_on), .clk_link(clk_link),
        .chip_select_n(chip_select_n), .link_chunk_start(chunk_start),
        .link_chunk_first(chunk_first));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] cfg_next(input logic [31:0] o, input logic [31:0] d);
        logic [2:0] c;
        c = (d[2:0] >= 3'h3 && d[2:0] <= 3'h6) ? d[2:0] : o[2:0];
        return {16'h0, d[15] | o[15], d[14:8], 2'h0, d[5], 2'h0, c};
    endfunction
    function automatic logic link_exp();
        if (cfg_exp[13]) return chunk_start & chunk_first;
        return cfg_exp[12] ? chunk_start : 1'b1;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        reg_req <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        reg_req.valid <= 1'b0;
    endtask
    task automatic wcfg(input logic [31:0] d);
        wr(ADDR_CFG, d);
        cfg_exp = cfg_next(cfg_exp, d);
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        reg_req <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 32'h0};
        @(negedge clk_sys);
        reg_req.valid <= 1'b0;
        if (reg_rsp_valid !== 1'b1) begin
            chk("read response", 32'h1, {31'h0, reg_rsp_valid});
            end_of_test();
        end else begin
            rd_val = reg_rdata;
        end
    endtask
    // s: 0 protection error, 1 protection clear, 2 reset-complete clear
    task automatic hit(input int s);
        @(negedge clk_sys);
        {ctrl_protect_err, protection_error_clr, reset_complete_clr} = 3'h4 >> s;
        @(negedge clk_sys);
        {ctrl_protect_err, protection_error_clr, reset_complete_clr} = 3'h0;
        @(negedge clk_sys);
    endtask

    always @(negedge clk_link) begin
        if (chk_link) begin
            chk("rx start", {31'h0, link_exp()}, {31'h0, link_rx_start_ok});
            chk("fcs check", {31'h0, cfg_exp[14]}, {31'h0, link_tx_fcs_check});
        end
    end

    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end

    initial begin
        {rstn, link_rstn, frame_on, chk_link, ctrl_protect_err} = 5'h0;
        {protection_error_clr, reset_complete_clr} = 2'h0;
        reg_req = '0;
        tx_credits = 6'h3F;
        seed = 32'h6E6E;
        cfg_exp = 32'h00000006;
        n_errors = 0;
        n_compared = 0;
        repeat (16) @(negedge clk_sys);
        frame_on = 1'b1;
        repeat (3) @(posedge clk_link);
        link_rstn <= 1'b1;
        @(negedge clk_sys);
        frame_on = 1'b0;
        rstn = 1'b1;
        rd(ADDR_CAP);
        chk("capabilities", CAP_EXP, rd_val);
        rd(ADDR_CFG);
        chk("config reset", 32'h00000006, rd_val);
        chk("reset complete", 32'h1, {31'h0, reset_complete_flag});
        wr(ADDR_CAP, 32'hFFFFFFFF);
        rd(ADDR_CAP);
        chk("capabilities written", CAP_EXP, rd_val);
        rd(8'h10);
        chk("unmapped", 32'h0, rd_val);
        for (int i = 0; i < 12; i++) begin
            w = rnd();
            w[15] = 1'b0;
            if (i < 8) w[2:0] = i[2:0];
            wcfg(w);
            rd(ADDR_CFG);
            chk("config word", cfg_exp, rd_val);
            chk("cfg fields", {20'h0, cfg_exp[15:8], cfg_exp[5], cfg_exp[2:0]},
                {20'h0, cfg});
            chk("frames accept", 32'h0, {31'h0, frames_accept});
        end
        wcfg(cfg_exp | 32'h00008000);
        chk("frames accept set", 32'h1, {31'h0, frames_accept});
        wcfg(32'h00000006);
        rd(ADDR_CFG);
        chk("config done sticky", cfg_exp, rd_val);
        for (int k = 0; k < 4; k++) begin
            wcfg({cfg_exp[31:12], k[1:0], cfg_exp[9:0]});
            thr = 6'h01 << (k == 0 ? 0 : k + 1);
            tx_credits = 6'h00;
            repeat (2) @(negedge clk_sys);
            tx_credits = thr - 6'h01;
            cnt = 0;
            repeat (4) @(negedge clk_sys) cnt += (tx_credit_irq === 1'b1);
            chk("irq below threshold", 32'h0, 32'(cnt));
            tx_credits = thr;
            cnt = 0;
            repeat (4) @(negedge clk_sys) cnt += (tx_credit_irq === 1'b1);
            chk("irq at threshold", 32'h1, 32'(cnt));
            tx_credits = 6'h3F;
        end
        wcfg(cfg_exp & ~32'h00000020);
        hit(0);
        chk("protect off", 32'h0, {31'h0, protection_error_flag});
        wcfg(cfg_exp | 32'h00000020);
        hit(0);
        chk("protect on", 32'h1, {31'h0, protection_error_flag});
        hit(1);
        chk("protect clear", 32'h0, {31'h0, protection_error_flag});
        for (int m = 0; m < 4; m++) begin
            wcfg({cfg_exp[31:15], m[0] ^ m[1], m[1:0], cfg_exp[11:0]});
            @(negedge clk_sys) frame_on = 1'b1;
            repeat (4) @(posedge clk_link);
            chk_link = 1'b1;
            repeat (20) @(posedge clk_link);
            chk_link = 1'b0;
            @(negedge clk_sys) frame_on = 1'b0;
        end
        hit(2);
        chk("reset complete clear", 32'h0, {31'h0, reset_complete_flag});
        @(negedge clk_sys) frame_on = 1'b1;
        wr(ADDR_RST, 32'h00000001);
        rd(ADDR_RST);
        chk("soft reset pending", 32'h1, rd_val);
        repeat (8) @(negedge clk_sys);
        chk("reset held by cs", 32'h0, {31'h0, mac_phy_reset});
        frame_on = 1'b0;
        cnt = 0;
        while (mac_phy_reset !== 1'b1 && cnt < 10) begin
            @(negedge clk_sys);
            cnt++;
        end
        chk("reset start", 32'h1, {31'h0, mac_phy_reset});
        cnt = 0;
        while (mac_phy_reset === 1'b1 && cnt < 300) begin
            @(negedge clk_sys);
            cnt++;
        end
        chk("reset length", SOFT_RST_CYC, 32'(cnt));
        rd(ADDR_RST);
        chk("soft reset cleared", 32'h0, rd_val);
        chk("reset complete set", 32'h1, {31'h0, reset_complete_flag});
        end_of_test();
    end
endmodule // mspc_regs_tb
`default_nettype wire
